// ---- rtl/dpm_pkg.sv ----
// Shared constants and carrier types for the upper code priority table
package dpm_pkg;

  // Widths and table shape
  localparam int DPM_ADDR_W = 4;
  localparam int DPM_DATA_W = 16;
  localparam int DPM_FIELD_W = 2;
  localparam int DPM_WORDS = 4;
  localparam int DPM_TABLE_W = 64;

  // Register offsets
  localparam logic [3:0] DPM_OFF_MAP_FIVE = 4'h8;
  localparam logic [3:0] DPM_OFF_MAP_SIX = 4'ha;
  localparam logic [3:0] DPM_OFF_MAP_SEVEN = 4'h0;
  localparam logic [3:0] DPM_OFF_MAP_EIGHT = 4'h2;

  // Word positions inside the 64-bit table
  localparam logic [1:0] DPM_IDX_FIVE = 2'h0;
  localparam logic [1:0] DPM_IDX_SIX = 2'h1;
  localparam logic [1:0] DPM_IDX_SEVEN = 2'h2;
  localparam logic [1:0] DPM_IDX_EIGHT = 2'h3;

  // Reset values
  localparam logic [15:0] DPM_MAP_RST = 16'h0000;
  localparam logic [15:0] DPM_RDATA_RST = 16'h0000;
  localparam logic [1:0] DPM_PRIO_RST = 2'h0;

  // Code field of the type-of-service byte and the first code of this half
  localparam int DPM_CODE_MSB = 7;
  localparam int DPM_CODE_LSB = 2;
  localparam logic [5:0] DPM_CODE_BASE = 6'h20;

  typedef logic [1:0] dpm_word_idx_t;
  typedef logic [63:0] dpm_table_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dpm_bus_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] tos;
  } dpm_lookup_req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [1:0] prio;
  } dpm_lookup_rsp_s;

endpackage

// ---- rtl/dpm_map_store.sv ----
// Four 16-bit priority map words, presented as one 64-bit table
`timescale 1ns/10ps
`default_nettype none

module dpm_map_store
  import dpm_pkg::*;
#(
  parameter int WORDS = DPM_WORDS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire dpm_word_idx_t wr_idx,
  input wire logic [15:0] wr_data,
  // Table
  output dpm_table_t table_q
);

  typedef struct packed {
    logic [WORDS-1:0][15:0] words;
  } dpm_store_st_s;

  dpm_store_st_s st_q;
  dpm_store_st_s st_d;
  logic [WORDS-1:0][15:0] word_d;

  for (genvar i = 0; i < WORDS; i++) begin : g_word
    assign word_d[i] = (wr_en && wr_idx == dpm_word_idx_t'(i)) ? wr_data : st_q.words[i];
  end

  always_comb begin
    st_d.words = word_d;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q.words <= {WORDS{DPM_MAP_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // Word five in the low bits, word eight in the high bits
  assign table_q = st_q.words;

endmodule

`default_nettype wire

// ---- rtl/dpm_field_sel.sv ----
// Picks the two-bit priority field addressed by a type-of-service byte
`timescale 1ns/10ps
`default_nettype none

module dpm_field_sel
  import dpm_pkg::*;
(
  // Table
  input wire dpm_table_t table_in,
  // Lookup
  input wire logic [7:0] tos,
  output logic hit,
  output logic [1:0] prio
);

  logic [5:0] code;
  logic [4:0] idx;

  assign code = tos[DPM_CODE_MSB:DPM_CODE_LSB];
  assign hit = code[5];
  // Code minus 32 selects the field; lowest code sits in bits 1-0
  assign idx = 5'(code - DPM_CODE_BASE);
  assign prio = table_in[{idx, 1'b0} +: DPM_FIELD_W];

endmodule

`default_nettype wire

// ---- rtl/dpm_priority_map_upper.sv ----
// Upper half of the code priority table: registers, lookup and checks
//
// Summary of operation
// - Priority comes from TOS byte bits 7 to 2
// - Map five serves 0x80..0x9c, low field first
// - Map six serves 0xa0..0xbc, low field first
// - Map seven serves 0xc0..0xdc, low field first
// - Map eight serves 0xe0..0xfc, low field first
`timescale 1ns/10ps
`default_nettype none

module dpm_priority_map_upper
  import dpm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire dpm_bus_req_s bus_req,
  output logic [15:0] reg_rdata,
  // Classification lookup
  input wire dpm_lookup_req_s lk_req,
  output dpm_lookup_rsp_s lk_rsp
);

  typedef struct packed {
    logic [15:0] rdata;
    dpm_lookup_rsp_s rsp;
  } dpm_top_st_s;

  dpm_top_st_s st_q;
  dpm_top_st_s st_d;

  dpm_table_t table_q;
  logic addr_hit;
  dpm_word_idx_t addr_idx;
  logic sel_hit;
  logic [1:0] sel_prio;
  logic store_wr;
  logic [15:0] word_rd;

  // Offset decode
  always_comb begin
    addr_hit = 1'b1;
    addr_idx = DPM_IDX_FIVE;
    case (bus_req.addr)
      DPM_OFF_MAP_FIVE: begin
        addr_idx = DPM_IDX_FIVE;
      end
      DPM_OFF_MAP_SIX: begin
        addr_idx = DPM_IDX_SIX;
      end
      DPM_OFF_MAP_SEVEN: begin
        addr_idx = DPM_IDX_SEVEN;
      end
      DPM_OFF_MAP_EIGHT: begin
        addr_idx = DPM_IDX_EIGHT;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  assign store_wr = bus_req.wr && addr_hit;
  assign word_rd = table_q[{addr_idx, 4'h0} +: DPM_DATA_W];

  dpm_map_store #(
    .WORDS(DPM_WORDS)
  ) u_store (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(store_wr),
    .wr_idx(addr_idx),
    .wr_data(bus_req.wdata),
    .table_q(table_q)
  );

  dpm_field_sel u_sel (
    .table_in(table_q),
    .tos(lk_req.tos),
    .hit(sel_hit),
    .prio(sel_prio)
  );

  always_comb begin
    st_d = st_q;
    // Read data stand for one cycle only; unmapped offsets read as zero
    st_d.rdata = (bus_req.rd && addr_hit) ? word_rd : DPM_RDATA_RST;
    st_d.rsp.valid = lk_req.valid;
    st_d.rsp.hit = lk_req.valid && sel_hit;
    // Codes below 0x80 belong to the lower half and give no priority here
    st_d.rsp.prio = (lk_req.valid && sel_hit) ? sel_prio : DPM_PRIO_RST;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q.rdata <= DPM_RDATA_RST;
      st_q.rsp.valid <= 1'b0;
      st_q.rsp.hit <= 1'b0;
      st_q.rsp.prio <= DPM_PRIO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign lk_rsp = st_q.rsp;

  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (reset);

  logic [7:0] chk_tos;
  assign chk_tos = lk_req.tos;

  a_write_five_store: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_FIVE
    |=> table_q[15:0] == $past(bus_req.wdata)
  ) else $error("map five did not take the written word");

  a_write_six_store: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_SIX
    |=> table_q[31:16] == $past(bus_req.wdata)
  ) else $error("map six did not take the written word");

  a_write_seven_store: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_SEVEN
    |=> table_q[47:32] == $past(bus_req.wdata)
  ) else $error("map seven did not take the written word");

  a_write_eight_store: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_EIGHT
    |=> table_q[63:48] == $past(bus_req.wdata)
  ) else $error("map eight did not take the written word");

  a_table_hold: assert property (
    !bus_req.wr |=> $stable(table_q)
  ) else $error("table changed without a write");

  a_read_back_data: assert property (
    bus_req.rd && addr_hit
    |=> reg_rdata == $past(word_rd)
  ) else $error("read data do not match the addressed word");

  a_read_idle_zero: assert property (
    !(bus_req.rd && addr_hit) |=> reg_rdata == 16'h0000
  ) else $error("read data not zero outside a mapped read");

  a_write_then_read: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_FIVE
    ##1 bus_req.rd && bus_req.addr == DPM_OFF_MAP_FIVE && !$past(bus_req.wr, 1) == 1'b0
    |=> reg_rdata == $past(bus_req.wdata, 2)
  ) else $error("write then read of map five lost the word");

  a_prio_low_code: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h20
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[1:0])
  ) else $error("code of byte 0x80 did not use bits 1-0 of map five");

  a_prio_six_low: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h28
    |=> lk_rsp.prio == $past(table_q[17:16])
  ) else $error("code of byte 0xa0 did not use bits 1-0 of map six");

  a_prio_seven_top: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h37
    |=> lk_rsp.prio == $past(table_q[47:46])
  ) else $error("code of byte 0xdc did not use bits 15-14 of map seven");

  a_prio_high_code: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h3f
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[63:62])
  ) else $error("code of byte 0xfc did not use bits 15-14 of map eight");

  a_tos_low_bits: assert property (
    lk_req.valid && chk_tos[7]
    |=> lk_rsp.prio == $past(table_q[{chk_tos[6:2], 1'b0} +: 2])
  ) else $error("priority not taken from code bits 7 to 2");

  a_lower_half_miss: assert property (
    lk_req.valid && !chk_tos[7]
    |=> !lk_rsp.hit && lk_rsp.prio == 2'h0
  ) else $error("lower-half code produced a hit");

  a_rsp_one_cycle: assert property (
    lk_rsp.valid == $past(lk_req.valid)
  ) else $error("lookup answer not exactly one cycle after request");

  // Further field ends of each map word, and middles of maps five and eight, from fixed bit positions
  a_prio_five_top: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h27
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[15:14])
  ) else $error("code of byte 0x9c did not use bits 15-14 of map five");

  a_prio_five_mid: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h22
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[5:4])
  ) else $error("code of byte 0x88 did not use bits 5-4 of map five");

  a_prio_six_top: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h2f
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[31:30])
  ) else $error("code of byte 0xbc did not use bits 15-14 of map six");

  a_prio_seven_low: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h30
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[33:32])
  ) else $error("code of byte 0xc0 did not use bits 1-0 of map seven");

  a_prio_eight_low: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h38
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[49:48])
  ) else $error("code of byte 0xe0 did not use bits 1-0 of map eight");

  a_prio_eight_mid: assert property (
    lk_req.valid && chk_tos[7:2] == 6'h3c
    |=> lk_rsp.hit && lk_rsp.prio == $past(table_q[57:56])
  ) else $error("code of byte 0xf0 did not use bits 9-8 of map eight");

  // A write touches its own word and leaves the other three alone
  a_write_five_only: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_FIVE
    |=> table_q[63:16] == $past(table_q[63:16])
  ) else $error("write to map five disturbed another word");

  a_write_six_only: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_SIX
    |=> {table_q[63:32], table_q[15:0]} == $past({table_q[63:32], table_q[15:0]})
  ) else $error("write to map six disturbed another word");

  a_write_seven_only: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_SEVEN
    |=> {table_q[63:48], table_q[31:0]} == $past({table_q[63:48], table_q[31:0]})
  ) else $error("write to map seven disturbed another word");

  a_write_eight_only: assert property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_EIGHT
    |=> table_q[47:0] == $past(table_q[47:0])
  ) else $error("write to map eight disturbed another word");

  a_unmapped_write_ignored: assert property (
    bus_req.wr && bus_req.addr != DPM_OFF_MAP_FIVE && bus_req.addr != DPM_OFF_MAP_SIX
    && bus_req.addr != DPM_OFF_MAP_SEVEN && bus_req.addr != DPM_OFF_MAP_EIGHT
    |=> $stable(table_q)
  ) else $error("write to an unmapped offset changed the table");

  // Read data per offset, from fixed word positions
  a_read_five_word: assert property (
    bus_req.rd && bus_req.addr == DPM_OFF_MAP_FIVE
    |=> reg_rdata == $past(table_q[15:0])
  ) else $error("read of map five returned the wrong word");

  a_read_six_word: assert property (
    bus_req.rd && bus_req.addr == DPM_OFF_MAP_SIX
    |=> reg_rdata == $past(table_q[31:16])
  ) else $error("read of map six returned the wrong word");

  a_read_seven_word: assert property (
    bus_req.rd && bus_req.addr == DPM_OFF_MAP_SEVEN
    |=> reg_rdata == $past(table_q[47:32])
  ) else $error("read of map seven returned the wrong word");

  a_read_eight_word: assert property (
    bus_req.rd && bus_req.addr == DPM_OFF_MAP_EIGHT
    |=> reg_rdata == $past(table_q[63:48])
  ) else $error("read of map eight returned the wrong word");

  a_read_unmapped_zero: assert property (
    bus_req.rd && bus_req.addr != DPM_OFF_MAP_FIVE && bus_req.addr != DPM_OFF_MAP_SIX
    && bus_req.addr != DPM_OFF_MAP_SEVEN && bus_req.addr != DPM_OFF_MAP_EIGHT
    |=> reg_rdata == 16'h0000
  ) else $error("read of an unmapped offset did not return zero");

  // Shape of the lookup answer
  a_idle_no_answer: assert property (
    !lk_req.valid
    |=> !lk_rsp.valid && !lk_rsp.hit && lk_rsp.prio == 2'h0
  ) else $error("lookup answer shown without a request");

  a_upper_half_hit: assert property (
    lk_req.valid && chk_tos[7]
    |=> lk_rsp.valid && lk_rsp.hit
  ) else $error("upper-half code did not produce a hit");

  c_write_read_five: cover property (
    bus_req.wr && bus_req.addr == DPM_OFF_MAP_FIVE ##1 bus_req.rd && bus_req.addr == DPM_OFF_MAP_FIVE
  );

  c_lookup_nonzero: cover property (
    lk_req.valid && chk_tos[7] ##1 lk_rsp.prio != 2'h0
  );

  c_unmapped_read: cover property (
    bus_req.rd && !addr_hit
  );

  c_top_code_hit: cover property (
    lk_req.valid && chk_tos[7:2] == 6'h3f ##1 lk_rsp.hit
  );

  c_read_eight_set: cover property (
    bus_req.rd && bus_req.addr == DPM_OFF_MAP_EIGHT ##1 reg_rdata != 16'h0000
  );

endmodule

`default_nettype wire

// ---- dv/dpm_priority_map_upper_test.sv ----
// Self-checking bench for the upper code priority table
`timescale 1ns/10ps
`default_nettype none

module dpm_priority_map_upper_test
  import dpm_pkg::*;
;
  logic clk_sys;
  logic reset;
  dpm_bus_req_s bus_req;
  logic [15:0] reg_rdata;
  dpm_lookup_req_s lk_req;
  dpm_lookup_rsp_s lk_rsp;
  int fails;
  int tests_run;
  logic [3:0] offs [4];
  logic [15:0] mdl [4];
  logic [15:0] pat [4];

  dpm_priority_map_upper u_dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus_req(bus_req),
    .reg_rdata(reg_rdata),
    .lk_req(lk_req),
    .lk_rsp(lk_rsp)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  // Write leaves the strobe up so a following access can come with no gap
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= {a, d, 1'b1, 1'b0};
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask

  function automatic logic [3:0] exp_rsp(input logic [7:0] tos);
    logic [5:0] idx;
    idx = tos[7:2] - 6'h20;
    if (tos < 8'h80) begin
      return 4'h8;
    end
    return {2'b11, mdl[idx[4:3]][idx[2:0] * 2 +: 2]};
  endfunction

  task automatic lk_chk(input logic [7:0] tos);
    @(posedge clk_sys);
    bus_req <= '0;
    lk_req <= {1'b1, tos};
    @(posedge clk_sys);
    lk_req <= '0;
    #1;
    chk("lk_rsp", {12'h000, exp_rsp(tos)}, {12'h000, lk_rsp});
  endtask

  task automatic all_regs();
    for (int i = 0; i < 4; i++) begin
      rd_chk(offs[i], mdl[i]);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    offs = '{DPM_OFF_MAP_FIVE, DPM_OFF_MAP_SIX, DPM_OFF_MAP_SEVEN, DPM_OFF_MAP_EIGHT};
    pat = '{16'he4b1, 16'h1b4e, 16'h9c63, 16'h36c9};
    mdl = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    fails = 0;
    tests_run = 0;
    reset = 1'b1;
    bus_req = '0;
    lk_req = '0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    all_regs();
    lk_chk(8'hfc);
    $display("test reset_values done");
    // Back-to-back write then read of each word
    for (int i = 0; i < 4; i++) begin
      wr_reg(offs[i], pat[i]);
      mdl[i] = pat[i];
      rd_chk(offs[i], pat[i]);
    end
    // Unmapped offsets ignore writes and read as zero
    wr_reg(4'h4, 16'hffff);
    wr_reg(4'h9, 16'hffff);
    rd_chk(4'h4, 16'h0000);
    rd_chk(4'h9, 16'h0000);
    all_regs();
    @(posedge clk_sys);
    #1;
    chk("reg_rdata idle", 16'h0000, reg_rdata);
    $display("test register_access done");
    // Every upper code, with the two low bits of the byte set both ways
    for (int t = 8'h80; t <= 8'hff; t++) begin
      lk_chk(t[7:0]);
    end
    lk_chk(8'h7c);
    lk_chk(8'h00);
    @(posedge clk_sys);
    #1;
    chk("lk_rsp idle", 16'h0000, {12'h000, lk_rsp});
    $display("test lookup_fields done");
    // Lookup right after a write sees the new word
    wr_reg(DPM_OFF_MAP_EIGHT, 16'h4000);
    mdl[3] = 16'h4000;
    lk_chk(8'hfd);
    lk_chk(8'he0);
    $display("test write_then_lookup done");
    // Reset in mid-run clears the table
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    mdl = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    all_regs();
    lk_chk(8'h9c);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
